/* File: src/ppc_pin_change.sv */
// Behaviour
// [RULE1] eight rising-edge enable bits, one per pin, arm low-to-high detection
// [RULE2] eight falling-edge enable bits, one per pin, arm high-to-low detection
// [RULE3] enabled rising edge on a pin sets that pin's change flag
// [RULE4] enabled falling edge on a pin sets that pin's change flag
// [RULE5] any enabled edge raises the summary change flag too
// [RULE6] enable bit at zero means that polarity never sets the flag
// [RULE7] flags read/write; writing zero clears, hardware set wins same cycle
// [RULE8] all enable and flag bits reset to zero on any reset
// [RULE9] software clears flags before enabling the interrupt; when the testbench re-enables it, it writes MASK before clearing STAT
// [RULE10] pins synchronised; edges found by comparing current and previous sample
// [RULE11] summary flag is OR of all pin flags, clears when all clear
module ppc_pin_change
    import ppc_pkg::*;
#(
    parameter int unsigned PINS = ppc_pkg::PPC_PINS
)(
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // port pins and event outputs
    input  wire logic [PINS-1:0]   port_pin,
    output logic                   change_summary_flag,
    output logic                   irq
);
    import ppc_pkg::*;

    // ==========================================================
    // state
    ppc_req_s          req_reg;
    logic [PINS-1:0]   rising_edge_enable_reg;
    logic [PINS-1:0]   falling_edge_enable_reg;
    logic [PINS-1:0]   pin_change_flag_reg;
    logic [PINS-1:0]   rise_seen;
    logic [PINS-1:0]   fall_seen;
    logic [PINS-1:0]   pin_set;
    logic [PINS-1:0]   pin_flag_next;
    logic [PPC_STAT_W-1:0] stat_reg;
    logic [PPC_STAT_W-1:0] mask_reg;
    logic [31:0]       hrdata_reg;

    // ==========================================================
    // address phase capture
    wire logic        addr_ok  = hsel & hready & htrans[1];
    ppc_req_s         req_next;
    assign req_next = '{sel: addr_ok, write: hwrite, addr: haddr[7:0]};

    function automatic logic hit(input ppc_req_s r, input logic [7:0] off);
        return r.sel & r.write & (r.addr == off);
    endfunction

    wire logic wr_rise = hit(req_reg, PPC_OFF_RISE);
    wire logic wr_fall = hit(req_reg, PPC_OFF_FALL);
    wire logic wr_flag = hit(req_reg, PPC_OFF_FLAG);
    wire logic wr_stat = hit(req_reg, PPC_OFF_STAT);
    wire logic wr_mask = hit(req_reg, PPC_OFF_MASK);

    // ==========================================================
    // per-pin edge detection, enables and change flags
    // one slice per pin, so PINS trims or widens the port without other edits
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++)
        begin : g_pin
            logic      sync1_reg;
            logic      sync2_reg;
            logic      prev_reg;
            logic      rise_en_reg;
            logic      fall_en_reg;
            logic      flag_reg;
            wire logic rise_hit;
            wire logic fall_hit;
            wire logic clr_req;
            wire logic flag_next;

            // two stages against metastability; prev follows the second stage,
            // so the first stage feeds nothing else
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    sync1_reg <= 1'b0;
                    sync2_reg <= 1'b0;
                    prev_reg  <= 1'b0;
                end
                else
                begin
                    sync1_reg <= port_pin[gi];                          // [RULE10]
                    sync2_reg <= sync1_reg;                             // [RULE10]
                    prev_reg  <= sync2_reg;                             // [RULE10]
                end
            end

            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    rise_en_reg <= 1'b0;                                // [RULE8]
                    fall_en_reg <= 1'b0;                                // [RULE8]
                end
                else
                begin
                    if (wr_rise)
                        rise_en_reg <= hwdata[gi];                      // [RULE1]
                    if (wr_fall)
                        fall_en_reg <= hwdata[gi];                      // [RULE2]
                end
            end

            // a pin held high at reset release looks like a rising edge two
            // cycles later; it is dropped unless a write issued in the first cycle after release has set an enable by then
            assign rise_seen[gi] = sync2_reg & ~prev_reg;               // [RULE10]
            assign fall_seen[gi] = ~sync2_reg & prev_reg;               // [RULE10]
            assign rise_hit      = rise_seen[gi] & rise_en_reg;         // [RULE3] [RULE6]
            assign fall_hit      = fall_seen[gi] & fall_en_reg;         // [RULE4] [RULE6]
            assign pin_set[gi]   = rise_hit | fall_hit;                 // [RULE3] [RULE4]

            // writing a zero clears the bit, a one leaves it; a new edge in the
            // same cycle wins so that no event is lost to a late clear
            assign clr_req   = wr_flag & ~hwdata[gi];
            assign flag_next = (flag_reg & ~clr_req) | pin_set[gi];     // [RULE7]

            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    flag_reg <= 1'b0;                                   // [RULE8]
                else
                    flag_reg <= flag_next;                              // [RULE7]
            end

            assign rising_edge_enable_reg[gi]  = rise_en_reg;
            assign falling_edge_enable_reg[gi] = fall_en_reg;
            assign pin_change_flag_reg[gi]     = flag_reg;
            assign pin_flag_next[gi]           = flag_next;
        end
    endgenerate

    // ==========================================================
    // summary flag and sticky status
    assign change_summary_flag = |pin_change_flag_reg;                  // [RULE5] [RULE11]

    // status bit: sticky any-edge event, write-one-to-clear, set wins
    wire logic [PPC_STAT_W-1:0] stat_set  = PPC_STAT_W'(|pin_set);
    wire logic [PPC_STAT_W-1:0] stat_clr  = wr_stat ? hwdata[PPC_STAT_W-1:0] : '0;
    wire logic [PPC_STAT_W-1:0] stat_next = (stat_reg & ~stat_clr) | stat_set; // [RULE5]

    // ==========================================================
    // read decode and select for the next data phase
    // a write still in its data phase lands at this edge; a read whose
    // address phase meets it must already see the new value
    wire logic [PINS-1:0]       rise_view = wr_rise ? hwdata[PINS-1:0] : rising_edge_enable_reg;
    wire logic [PINS-1:0]       fall_view = wr_fall ? hwdata[PINS-1:0] : falling_edge_enable_reg;
    wire logic [PINS-1:0]       flag_view = pin_flag_next;
    wire logic [PPC_STAT_W-1:0] stat_view = stat_next;
    wire logic [PPC_STAT_W-1:0] mask_view = wr_mask ? hwdata[PPC_STAT_W-1:0] : mask_reg;

    wire logic [7:0] ra      = haddr[7:0];
    wire logic       rd_req  = addr_ok & ~hwrite;
    wire logic       rd_rise = rd_req & (ra == PPC_OFF_RISE);
    wire logic       rd_fall = rd_req & (ra == PPC_OFF_FALL);
    wire logic       rd_flag = rd_req & (ra == PPC_OFF_FLAG);
    wire logic       rd_stat = rd_req & (ra == PPC_OFF_STAT);
    wire logic       rd_mask = rd_req & (ra == PPC_OFF_MASK);

    // unmapped offsets match no select and read as zero
    wire logic [31:0] rd_next = ({32{rd_rise}} & 32'(rise_view))
                              | ({32{rd_fall}} & 32'(fall_view))
                              | ({32{rd_flag}} & 32'(flag_view))
                              | ({32{rd_stat}} & 32'(stat_view))
                              | ({32{rd_mask}} & 32'(mask_view));

    // ==========================================================
    // registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            stat_reg <= '0;                                             // [RULE8]
        else
            stat_reg <= stat_next;                                      // [RULE5]
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mask_reg <= '0;
        else if (wr_mask)
            mask_reg <= hwdata[PPC_STAT_W-1:0];
    end

    // the master moves on after the address phase; the data phase uses this copy
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            req_reg <= '0;
        else
            req_reg <= req_next;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_reg <= 32'h0000_0000;
        else
            hrdata_reg <= rd_next;
    end

    // zero wait states: every transfer finishes in its first data-phase cycle
    assign hrdata    = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = PPC_HRESP_OKAY;
    assign irq       = |(stat_reg & mask_reg);

endmodule // ppc_pin_change

/* File: src/ppc_pkg.sv */
package ppc_pkg;

    // ==========================================================
    // widths
    localparam int unsigned PPC_PINS     = 8;
    localparam int unsigned PPC_AW       = 8;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] PPC_OFF_RISE  = 8'h00;
    localparam logic [7:0] PPC_OFF_FALL  = 8'h04;
    localparam logic [7:0] PPC_OFF_FLAG  = 8'h08;
    localparam logic [7:0] PPC_OFF_STAT  = 8'h0c;
    localparam logic [7:0] PPC_OFF_MASK  = 8'h10;

    // ==========================================================
    // status bit positions and reset values
    localparam int unsigned PPC_STAT_SUM = 0;
    localparam int unsigned PPC_STAT_W   = 1;
    localparam logic [7:0] PPC_RST_BYTE  = 8'h00;

    // ==========================================================
    // ahb encodings
    localparam logic [1:0] PPC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] PPC_HTRANS_SEQ    = 2'h3;
    localparam logic       PPC_HRESP_OKAY    = 1'h0;

    typedef struct packed {
        logic       sel;
        logic       write;
        logic [7:0] addr;
    } ppc_req_s;

endpackage : ppc_pkg

/* File: sim/ppc_pin_src.sv */
module ppc_pin_src
    import ppc_pkg::*;
(
    // clock and wanted levels
    input  logic                hclk,
    input  logic [PPC_PINS-1:0] level,
    // pins
    output logic [PPC_PINS-1:0] port_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial port_pin = '0;
    // levels move just after an edge and hold whole cycles, never a sub-clock pulse
    always @(posedge hclk) port_pin <= level;
endmodule // ppc_pin_src

/* File: sim/ppc_pin_change_monitor.sv */
module ppc_pin_change_monitor
    import ppc_pkg::*;
#(parameter int unsigned PINS = 8)(
    // bus
    input logic        hclk,
    input logic        hresetn,
    input logic        hsel,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic        hready,
    input logic [31:0] hrdata,
    input logic        hreadyout,
    input logic        hresp,
    // pins and events
    input logic [PINS-1:0] port_pin,
    input logic        change_summary_flag,
    input logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [PINS-1:0] pp;
    logic [2:0]      cnt;
    logic [2:0]      wrq;
    logic            rdq;
    wire             acc = hsel && hready && htrans[1];
    // cnt saturates: cycles since a pin moved; wrq marks write address phases in each of the last three cycles
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            {pp, cnt, wrq, rdq} <= {{PINS{1'h0}}, 3'h7, 4'h0};
        else
            {pp, cnt, wrq, rdq} <= {port_pin, (port_pin != pp) ? 3'h0 : cnt + 3'(cnt != 3'h7),
                                    wrq[1:0], acc && hwrite, acc && !hwrite};
    // ==========
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_phase;
        rdq;
    endsequence
    rst_zero_a: assert property ($rose(hresetn) |-> !change_summary_flag && !irq)
        else $error("not clear after reset");
    bus_ok_a: assert property (hreadyout && hresp == PPC_HRESP_OKAY)
        else $error("bus not ready");
    sum_cause_a: assert property ($rose(change_summary_flag) |-> cnt <= 3'h5)
        else $error("summary without edge");
    sum_clear_a: assert property ($fell(change_summary_flag) |-> |wrq)
        else $error("summary fell alone");
    irq_cause_a: assert property ($rose(irq) |-> cnt <= 3'h5 || |wrq)
        else $error("irq without cause");
    irq_clear_a: assert property ($fell(irq) |-> |wrq)
        else $error("irq fell alone");
    rd_high_a: assert property (rd_phase |-> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    rd_idle_a: assert property (!rdq |-> hrdata == 32'h0)
        else $error("read data outside read");
endmodule // ppc_pin_change_monitor

bind ppc_pin_change ppc_pin_change_monitor #(.PINS(PINS)) u_mon (.hclk, .hresetn, .hsel,
    .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .port_pin, .change_summary_flag, .irq);

/* File: sim/tb_port_pin_change_interrupt.sv */
module tb_port_pin_change_interrupt;
    timeunit 1ns;
    timeprecision 1ps;
    import ppc_pkg::*;
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    logic [7:0]  level = 8'h0;
    wire  [31:0] hrdata;
    wire  [7:0]  port_pin;
    wire         hreadyout, hresp, sum, irq;
    int          rise, fall, flg, stat, mask, prev, nv, e, i, seed, n_errors, samples_checked;
    always #4 hclk = ~hclk;
    ppc_pin_change dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .port_pin, .change_summary_flag(sum), .irq);
    ppc_pin_src u_src (.hclk, .level, .port_pin);
    // ==========
    // bus tasks
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
        int k;
        {hsel, haddr, htrans, hwrite} <= {1'h1, 24'h0, a, PPC_HTRANS_NONSEQ, w};
        for (int p = 0; p < 2; p++)
        begin
            k = 0;
            do
            begin
                @(posedge hclk);
                k++;
            end
            while (hreadyout !== 1'h1 && k < 9);
            if (hreadyout !== 1'h1)
            begin
                n_errors++;
                finish_test;
            end
            if (p == 0)
                {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
        end
        q = hrdata;
    endtask
    task automatic rd(string nm, logic [7:0] a, logic [31:0] exp);
        xfer(1'h0, a, 32'h0);
        chk(nm, q, exp);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ==========
    // sequence
    initial
    begin
        seed = 85;
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        for (i = 0; i < 6; i++) rd("reset", 8'(i * 4), 32'h0);
        xfer(1'h1, PPC_OFF_STAT, 32'h1);
        mask = 1;
        xfer(1'h1, PPC_OFF_MASK, mask);
        for (i = 0; i < 40; i++)
        begin
            rise = $random(seed) & 255;
            fall = $random(seed) & 255;
            nv = $random(seed) & 255;
            xfer(1'h1, PPC_OFF_RISE, rise);
            xfer(1'h1, PPC_OFF_FALL, fall);
            rd("rise", PPC_OFF_RISE, rise);
            rd("fall", PPC_OFF_FALL, fall);
            level <= 8'(nv);
            e = (prev ^ nv) & (nv & rise | ~nv & fall);
            flg |= e;
            stat |= e != 0;
            prev = nv;
            repeat (6) @(posedge hclk);
            rd("flag", PPC_OFF_FLAG, flg);
            rd("stat", PPC_OFF_STAT, stat);
            chk("sum", sum, flg != 0);
            chk("irq", irq, stat & mask);
            nv = $random(seed) & 255;
            xfer(1'h1, PPC_OFF_FLAG, nv);
            flg &= nv;
            if (i % 5 == 4)
            begin
                mask ^= 1;
                xfer(1'h1, PPC_OFF_MASK, mask);
                xfer(1'h1, PPC_OFF_STAT, 32'h1);
                stat = 0;
            end
        end
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        for (i = 0; i < 6; i++) rd("reset", 8'(i * 4), 32'h0);
        finish_test;
    end
endmodule // tb_port_pin_change_interrupt
